//--- core/wake_timer_pkg.sv
// constants, register map and shared types of the wake-up timer block
// assumes a single 20 MHz bus clock; the 32.768 kHz time base is derived from it
package wake_timer_pkg;

    // clock rates: the time base is made by a fractional accumulator
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BASE_HZ = 32_768;
    localparam int ACC_W = 25;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BASE_HZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);

    // one mantissa unit is 4 x 2^exp base ticks, so the prescaler needs 2 + 20 bits
    localparam int UNIT_SHIFT = 2;
    localparam int PRE_W = 23;
    localparam logic [4:0] EXP_MAX = 5'h14;

    // register indices; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_EXP = 8'h14;
    localparam logic [7:0] IDX_PER_HI = 8'h15;
    localparam logic [7:0] IDX_PER_LO = 8'h16;
    localparam logic [7:0] IDX_CNT_HI = 8'h17;
    localparam logic [7:0] IDX_CNT_LO = 8'h18;
    localparam logic [7:0] IDX_WIN_LEN = 8'h19;
    localparam logic [7:0] IDX_CTRL = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [7:0] IDX_MASK = 8'h32;

    // reset values
    localparam logic [4:0] RST_EXP = 5'h03;
    localparam logic [7:0] RST_PER_HI = 8'h00;
    localparam logic [7:0] RST_PER_LO = 8'h01;
    localparam logic [7:0] RST_WIN_LEN = 8'h01;
    localparam logic [1:0] RST_CTRL = 2'h0;

    // control and event bit positions
    localparam int CTRL_WAKE_EN = 0;
    localparam int CTRL_WIN_EN = 1;
    localparam int EVT_W = 2;
    localparam int EVT_WAKE = 0;
    localparam int EVT_WIN_END = 1;

    // timer settings as seen by the counting logic
    typedef struct packed {
        logic [15:0] mant;
        logic [4:0] exp;
        logic [7:0] win_len;
    } wake_cfg_t;

endpackage

//--- core/time_base.sv
// 32.768 kHz tick enable made from the bus clock
// assumes pclk at the rate named in the package; average rate is exact, jitter one cycle
module time_base
(
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    import wake_timer_pkg::*;

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W:0] sum;

    assign sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};

    // fractional accumulator: a plain divide by 610 would drift by 0.06 percent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_reg <= '0;
            tick <= 1'b0;
        end
        else if (sum >= {1'b0, ACC_MOD})
        begin
            acc_reg <= ACC_W'(sum - {1'b0, ACC_MOD});
            tick <= 1'b1;
        end
        else
        begin
            acc_reg <= sum[ACC_W-1:0];
            tick <= 1'b0;
        end
    end

endmodule // time_base

//--- core/unit_divider.sv
// divides the base tick by 4 x 2^exp to give one mantissa step
// assumes exp is already clamped and held stable while run is high
module unit_divider
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic tick,
    input wire logic [4:0] exp_eff,
    output logic step
);
    import wake_timer_pkg::*;

    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] limit;

    assign limit = (PRE_W'(1) << (exp_eff + 5'(UNIT_SHIFT))) - PRE_W'(1); // [RL1] [RL8]

    // prescaler restarts from zero whenever the timer is stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg <= '0;
            step <= 1'b0;
        end
        else if (!run)
        begin
            pre_reg <= '0;
            step <= 1'b0;
        end
        else if (tick && pre_reg == limit)
        begin
            pre_reg <= '0;
            step <= 1'b1; // [RL1]
        end
        else
        begin
            pre_reg <= tick ? pre_reg + PRE_W'(1) : pre_reg;
            step <= 1'b0;
        end
    end

    a_unit_step_cause: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        step |-> $past(tick) && $past(pre_reg) == $past(limit) && $past(run))
        else $error("mantissa step without a full prescaler run");

endmodule // unit_divider

//--- core/wake_timer.sv
// periodic wake-up timer with an on-window generator, registers on apb
// assumes a 20 MHz pclk, an apb master with 32-bit data, byte address = 4 x index
//
// Notes on behaviour
// RL1 - wake period is 4 x mantissa x 2^exp base ticks at 32.768 kHz.
// RL2 - period mantissa is 16 bits, held as read/write high and low bytes.
// RL3 - software never writes zero into the low mantissa byte.
// RL4 - running mantissa count reads back as two read-only bytes.
// RL5 - each on-window starts exactly when a wake period starts.
// RL6 - software keeps the on-window length below the period mantissa.
// RL7 - software never writes zero as the on-window length.
// RL8 - on-window lasts 4 x length x 2^exp base ticks, same exponent.
// RL9 - exponent above 20 acts as 20; zero is allowed.
// RL10 - software disables the function before changing its settings.
// RL11 - count reaching the period raises a wake flag and restarts at zero.
module wake_timer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wake_timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic on_window,
    output logic wake_pulse
);
    import wake_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [4:0] exp_reg;
    logic [7:0] per_hi_reg;
    logic [7:0] per_lo_reg;
    logic [7:0] win_len_reg;
    logic [1:0] ctrl_reg;
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] mask_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic on_window_next;
    wake_cfg_t cfg;
    logic [4:0] exp_eff;
    logic run;
    logic win_en;
    logic tick;
    logic step;
    logic wrap;
    logic setup;
    logic wr_en;
    logic [7:0] idx;
    logic hit;
    logic [31:0] rd_val;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [EVT_W-1:0] status_next;
    logic [7:0] win_steps_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // settings and time base

    // settings gathered for the counting logic
    assign cfg = '{mant: {per_hi_reg, per_lo_reg}, exp: exp_reg, win_len: win_len_reg}; // [RL2]
    assign exp_eff = (cfg.exp > EXP_MAX) ? EXP_MAX : cfg.exp; // [RL9]
    assign run = ctrl_reg[CTRL_WAKE_EN];
    assign win_en = ctrl_reg[CTRL_WIN_EN];

    time_base u_time_base
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    unit_divider u_unit_divider
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .tick(tick),
        .exp_eff(exp_eff),
        .step(step)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // mantissa counter and on-window

    // >= rather than == so a period lowered on the fly still wraps; software is
    // meant to stop the timer first, this only keeps the count from running away
    assign wrap = step && (count_reg >= cfg.mant - 16'h0001); // [RL11] [RL10]

    // next count, used so the window flop lines up with the period start
    always_comb
    begin
        if (!run)
            count_next = 16'h0000;
        else if (wrap)
            count_next = 16'h0000; // [RL11]
        else if (step)
            count_next = count_reg + 16'h0001; // [RL1]
        else
            count_next = count_reg;
    end

    // window high while the count is below the length: opens at count zero
    assign on_window_next = run && win_en && (count_next < {8'h00, cfg.win_len}); // [RL5] [RL8]

    // counter restarts from zero every time the timer is enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= 16'h0000;
        else
            count_reg <= count_next; // [RL4]
    end

    // registered outputs of the timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_window <= 1'b0;
            wake_pulse <= 1'b0;
        end
        else
        begin
            on_window <= on_window_next; // [RL5] [RL8]
            wake_pulse <= wrap; // [RL11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave

    // register map, byte address = 4 x index:
    //   0x14 exponent, bits 4:0, values above twenty act as twenty
    //   0x15 / 0x16 period mantissa, high / low byte
    //   0x17 / 0x18 running count, high / low byte, read only, writes ignored
    //   0x19 on-window length in mantissa steps
    //   0x30 control: bit 0 wake timer enable, bit 1 on-window enable
    //   0x31 status: bit 0 period end, bit 1 window end, write one to clear
    //   0x32 interrupt mask, same layout as status
    // the two count bytes are not read atomically: read twice, as stopping the timer clears
    // the count to zero; a step between the two reads can carry into the high byte

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign idx = paddr[9:2];

    // read mux and decode; misaligned or out-of-range addresses miss
    always_comb
    begin
        rd_val = 32'h0000_0000;
        hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
        case (idx)
            IDX_EXP: rd_val = {27'h0, exp_reg};
            IDX_PER_HI: rd_val = {24'h0, per_hi_reg}; // [RL2]
            IDX_PER_LO: rd_val = {24'h0, per_lo_reg}; // [RL2]
            IDX_CNT_HI: rd_val = {24'h0, count_reg[15:8]}; // [RL4]
            IDX_CNT_LO: rd_val = {24'h0, count_reg[7:0]}; // [RL4]
            IDX_WIN_LEN: rd_val = {24'h0, win_len_reg};
            IDX_CTRL: rd_val = {30'h0, ctrl_reg};
            IDX_STATUS: rd_val = {30'h0, status_reg};
            IDX_MASK: rd_val = {30'h0, mask_reg};
            default: hit = 1'b0;
        endcase
        if (!hit)
            rd_val = 32'h0000_0000;
    end

    // zero wait states: answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite)
                prdata <= rd_val;
        end
    end

    // writable settings; the count bytes ignore writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exp_reg <= RST_EXP;
            per_hi_reg <= RST_PER_HI;
            per_lo_reg <= RST_PER_LO;
            win_len_reg <= RST_WIN_LEN;
            ctrl_reg <= RST_CTRL;
            mask_reg <= '0;
        end
        else if (wr_en && hit)
        begin
            case (idx)
                IDX_EXP: exp_reg <= pwdata[4:0];
                IDX_PER_HI: per_hi_reg <= pwdata[7:0]; // [RL2]
                IDX_PER_LO: per_lo_reg <= pwdata[7:0]; // [RL2]
                IDX_WIN_LEN: win_len_reg <= pwdata[7:0]; // [RL8]
                IDX_CTRL: ctrl_reg <= pwdata[1:0];
                IDX_MASK: mask_reg <= pwdata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // events and interrupt

    assign evt_set = {on_window && !on_window_next, wrap};
    assign evt_clr = (wr_en && hit && idx == IDX_STATUS) ? pwdata[EVT_W-1:0] : '0;

    // next flag value, one copy of the logic per event bit; the set term wins over a
    // clear in the same cycle, so an event that lands together with a clear is kept
    for (genvar g = 0; g < EVT_W; g++)
    begin : g_flag
        assign status_next[g] = evt_set[g] | (status_reg[g] & ~evt_clr[g]); // [RL11]
    end

    // sticky flags, write one to clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= '0;
        else
            status_reg <= status_next; // [RL11]
    end

    // level interrupt, one cycle behind the flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    //
    // these assume software keeps its side: no zero length or low period byte, length
    // below the period, and settings changed only while the timer is stopped

    // checker helper: mantissa steps seen while the on-window is open; it restarts
    // from zero at every opening because the window is always closed the cycle before,
    // the length being below the period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            win_steps_reg <= 8'h00;
        else if (!on_window)
            win_steps_reg <= 8'h00;
        else if (step)
            win_steps_reg <= win_steps_reg + 8'h01;
    end

    // timer checks
    a_wrap_restart: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        wrap && run |=> count_reg == 16'h0000 && wake_pulse && status_reg[EVT_WAKE])
        else $error("period end did not restart the count and flag the wake");

    a_count_advance: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        run && step && !wrap |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("mantissa count did not advance on a step");

    a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        run && !step |=> count_reg == $past(count_reg))
        else $error("mantissa count moved without a step");

    a_count_in_range: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        run && cfg.mant != 16'h0000 |-> count_reg < cfg.mant)
        else $error("mantissa count reached the period without restarting");

    a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        !run |=> count_reg == 16'h0000 && !on_window)
        else $error("stopped timer did not return to count zero");

    a_wake_single: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");

    a_window_opens: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        wrap && run && win_en |=> on_window)
        else $error("on-window did not open with the new period");

    a_window_rise_start: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        $rose(on_window) && $past(run) |-> count_reg == 16'h0000)
        else $error("on-window opened away from a period start");

    a_window_length: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        $past(run) && $past(win_en) && run && win_en
        |-> on_window == (count_reg < {8'h00, win_len_reg}))
        else $error("on-window level disagrees with count and length");

    a_window_steps: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        run && win_en && on_window && !on_window_next |=> win_steps_reg == win_len_reg)
        else $error("on-window did not last the programmed number of steps");

    a_exp_clamp: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        exp_eff == ((exp_reg > EXP_MAX) ? EXP_MAX : exp_reg) && exp_eff <= EXP_MAX)
        else $error("exponent not limited to twenty");

    // bus and flag checks
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle right after setup");

    a_bad_address: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        psel && !penable && !hit |=> pready && pslverr)
        else $error("unmapped address answered without an error");

    a_period_store: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        wr_en && paddr == {2'h0, IDX_PER_LO, 2'h0}
        |=> per_lo_reg == $past(pwdata[7:0]))
        else $error("low period byte not stored on write");

    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        evt_clr[EVT_WAKE] && !evt_set[EVT_WAKE] |=> !status_reg[EVT_WAKE])
        else $error("wake flag not cleared by a one written to it");

    a_sticky_wake: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        status_reg[EVT_WAKE] && !evt_clr[EVT_WAKE] |=> status_reg[EVT_WAKE])
        else $error("wake flag dropped without a clear");

    a_window_end_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        on_window && !on_window_next |=> status_reg[EVT_WIN_END])
        else $error("window end did not raise its flag");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        irq == $past(|(status_reg & mask_reg)))
        else $error("interrupt level does not follow masked flags");

endmodule // wake_timer

//--- verification/test_wake_timer.sv
// self-checking bench for the wake-up timer block, driven over apb
// assumes wake_timer from core/ with a 20 MHz pclk and zero-wait apb
module test_wake_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import wake_timer_pkg::*;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic on_window;
    logic wake_pulse;
    int failures;
    int compares;
    int cyc;
    int t0;
    int t1;
    int tf;
    logic [31:0] rd;
    logic er;
    logic [31:0] v;
    logic [7:0] ridx [9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h30, 8'h31, 8'h32};
    logic [31:0] rval [9] = '{32'h3, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

    ////////////////////////////////////////////////////////////////////////////////
    wake_timer dut
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .on_window(on_window),
        .wake_pulse(wake_pulse)
    );

    // free-running clock and a cycle count for interval measurement
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for a wake pulse (p=1) or the fall of the on-window (p=0), bounded
    task automatic wt(input logic p, output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((p ? wake_pulse !== 1'b1 : on_window !== 1'b0) && n < 25000);
        if (n >= 25000) failures++;
        t = cyc;
    endtask

    // a span of base ticks in bus clocks; the time base jitters by a cycle
    function automatic logic near(input int got, input int ticks);
        int e;
        e = (ticks * 20000000 + 16384) / 32768;
        return (got - e <= 3) && (e - got <= 3);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: the whole sequence needs a little under half of this
    initial
    begin
        #(90000 * 50);
        failures++;
        end_sim();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        presetn = 1'b0;
        failures = 0;
        compares = 0;
        v = $urandom(79);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every mapped register
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, ridx[i], 32'h0);
            chk(rd, rval[i]);
        end
        // unmapped place answers with an error; the low count byte ignores writes
        apb(1'b1, 8'h20, 32'h5A);
        chk(er, 1'b1);
        apb(1'b1, IDX_CNT_LO, 32'hAA);
        apb(1'b0, IDX_CNT_LO, 32'h0);
        chk(rd, 32'h0);
        // random settings read back; zero kept out of low byte and length
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            apb(1'b1, IDX_PER_HI, {24'h0, v[7:0]});
            apb(1'b1, IDX_PER_LO, {24'h0, v[15:9], 1'b1});
            apb(1'b1, IDX_WIN_LEN, {24'h0, v[23:17], 1'b1});
            apb(1'b0, IDX_PER_HI, 32'h0);
            chk(rd, {24'h0, v[7:0]});
            apb(1'b0, IDX_PER_LO, 32'h0);
            chk(rd, {24'h0, v[15:9], 1'b1});
            apb(1'b0, IDX_WIN_LEN, 32'h0);
            chk(rd, {24'h0, v[23:17], 1'b1});
        end
        // period 2 units, window 1 unit, for two exponents; wake event masked
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, IDX_EXP, e);
            apb(1'b1, IDX_PER_HI, 32'h0);
            apb(1'b1, IDX_PER_LO, 32'h2);
            apb(1'b1, IDX_WIN_LEN, 32'h1);
            apb(1'b1, IDX_MASK, 32'h0);
            apb(1'b1, IDX_CTRL, 32'h3);
            wt(1'b1, t0);
            repeat (2) @(posedge pclk);
            chk(on_window, 1'b1);
            chk(wake_pulse, 1'b0);
            wt(1'b0, tf);
            chk(near(tf - t0, 4 << e), 1'b1);
            wt(1'b1, t1);
            chk(near(t1 - t0, 8 << e), 1'b1);
            apb(1'b0, IDX_STATUS, 32'h0);
            chk(rd[0], 1'b1);
            chk(irq, 1'b0);
            apb(1'b1, IDX_MASK, 32'h1);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b1);
            apb(1'b1, IDX_STATUS, 32'h3);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
            apb(1'b1, IDX_CTRL, 32'h0);
        end
        // running count, window off: 14 base ticks in, three units have passed
        apb(1'b1, IDX_EXP, 32'h0);
        apb(1'b1, IDX_PER_HI, 32'h1);
        apb(1'b1, IDX_PER_LO, 32'h5);
        apb(1'b1, IDX_CTRL, 32'h1);
        repeat (8545) @(posedge pclk);
        chk(on_window, 1'b0);
        apb(1'b0, IDX_CNT_HI, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, IDX_CNT_LO, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, IDX_CTRL, 32'h0);
        end_sim();
    end
endmodule // test_wake_timer
